/* File: hw/szad_defines.svh */
// Notes on behaviour
// - Config zone takes 4-byte word or 32-byte block accesses only.
// - Config zone decodes address bits [4:0] only; higher bits ignored.
// - Config bits [4:3] pick block, [2:0] word; byte = blk*32+word*4.
// - Config and OTP zones accept reads only; writes are refused.
// - OTP zone is 64 bytes, word or block access only.
// - OTP decodes bits [3:0]: bit 3 block, bits [2:0] word.
// - Data zone has 16 slots of varied size, each with own policy.
// - Clear-text writes allowed only to slots 8, 9, 13 and 15.
// - Slots 5 and 6 may be written only with encrypted data.
// - Clear-text reads allowed on slot 8 and slots 10 to 15.
// - Every slot without a grant above is neither readable nor writable.
// - Data slot from bits [6:3], word from [2:0], bit 7 ignored.
// - Block field: slots 0-7 bit 8, slot 8 [11:8], slots 9-15 [9:8].
// - Slots 0-7 hold 36 bytes; block 1 only word 0 valid.
// - Slot 8 spans blocks 0 to 0xC, bytes 0 to 415.
// - Slots 9-15 hold 72 bytes; block 2 only words 0 and 1 valid.
`ifndef SZAD_DEFINES_SVH
`define SZAD_DEFINES_SVH

// Address field positions
`define SZAD_WORD_LSB      0
`define SZAD_WORD_MSB      2
`define SZAD_CFG_BLK_LSB   3
`define SZAD_CFG_BLK_MSB   4
`define SZAD_OTP_BLK_BIT   3
`define SZAD_SLOT_LSB      3
`define SZAD_SLOT_MSB      6
`define SZAD_DBLK_LSB      8
`define SZAD_DBLK_MSB      11

// Bytes per unit
`define SZAD_WORD_BYTES    4
`define SZAD_BLOCK_BYTES   32

// Data slot geometry: last block and words valid in that last block
`define SZAD_SMALL_LAST_BLK 4'h1
`define SZAD_SMALL_LAST_WDS 4'h1
`define SZAD_BIG_LAST_BLK   4'hC
`define SZAD_BIG_LAST_WDS   4'h8
`define SZAD_MID_LAST_BLK   4'h2
`define SZAD_MID_LAST_WDS   4'h2
`define SZAD_BIG_SLOT       4'h8
`define SZAD_SMALL_SLOT_MAX 4'h7

// Slot permission masks, one bit per slot
`define SZAD_WR_CLEAR_MASK  16'hA300
`define SZAD_WR_ENC_MASK    16'h0060
`define SZAD_RD_CLEAR_MASK  16'hFD00

// Reset values
`define SZAD_RST_BYTE       12'h000
`define SZAD_RST_STATUS     8'h00

`endif

/* File: hw/szad_pkg.sv */
package szad_pkg;
   typedef enum logic [1:0] {
      SZAD_ZONE_CFG  = 2'b00,
      SZAD_ZONE_OTP  = 2'b01,
      SZAD_ZONE_DATA = 2'b10
   } szad_zone_t;

   typedef enum logic [7:0] {
      SZAD_ST_OK    = 8'h00,
      SZAD_ST_PARSE = 8'h03,
      SZAD_ST_EXEC  = 8'h0F
   } szad_status_t;
endpackage

/* File: hw/szad_req_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Decoded request passed from top to the slot checker
interface szad_req_if;
   logic [3:0] slot;
   logic [3:0] blk;
   logic [2:0] word;
   logic       is_block;
   logic       is_write;
   logic       encrypted;
   logic       ok;
   modport top (output slot, blk, word, is_block, is_write, encrypted,
                input ok);
   modport chk (input slot, blk, word, is_block, is_write, encrypted,
                output ok);
endinterface
`default_nettype wire

/* File: hw/szad_slot_check.sv */
`timescale 1ns/1ps
`default_nettype none
`include "szad_defines.svh"
module szad_slot_check (
   szad_req_if.chk req
);
   import szad_pkg::*;
   logic [3:0] last_blk;
   logic [3:0] last_wds;
   logic       geom_ok;
   logic       perm_ok;

   // Grant masks kept as vectors so each slot picks its own bit
   localparam logic [15:0] wr_clear_grant = `SZAD_WR_CLEAR_MASK;
   localparam logic [15:0] wr_enc_grant   = `SZAD_WR_ENC_MASK;
   localparam logic [15:0] rd_clear_grant = `SZAD_RD_CLEAR_MASK;

   // Slot size class picks the last block and the words valid in it
   always_comb begin
      if (req.slot <= `SZAD_SMALL_SLOT_MAX) begin
         last_blk = `SZAD_SMALL_LAST_BLK;
         last_wds = `SZAD_SMALL_LAST_WDS;
      end else if (req.slot == `SZAD_BIG_SLOT) begin
         last_blk = `SZAD_BIG_LAST_BLK;
         last_wds = `SZAD_BIG_LAST_WDS;
      end else begin
         last_blk = `SZAD_MID_LAST_BLK;
         last_wds = `SZAD_MID_LAST_WDS;
      end
   end

   // Block access needs a full last block; word access a valid word
   always_comb begin
      if (req.blk > last_blk) begin
         geom_ok = 1'b0;
      end else if (req.blk < last_blk) begin
         geom_ok = 1'b1;
      end else if (req.is_block) begin
         geom_ok = (last_wds == `SZAD_BIG_LAST_WDS);
      end else begin
         geom_ok = ({1'b0, req.word} < last_wds);
      end
   end

   // Fixed per-slot policy; ungranted slots fall to zero
   always_comb begin
      if (req.is_write) begin
         if (req.encrypted) begin
            perm_ok = wr_enc_grant[req.slot];
         end else begin
            perm_ok = wr_clear_grant[req.slot];
         end
      end else begin
         perm_ok = rd_clear_grant[req.slot];
      end
   end

   assign req.ok = geom_ok & perm_ok;
endmodule
`default_nettype wire

/* File: hw/szad_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "szad_defines.svh"
module szad_decoder (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   // Request
   input  wire logic                 req_valid,
   input  szad_pkg::szad_zone_t      req_zone,
   input  wire logic [15:0]          req_addr,
   input  wire logic                 req_block,
   input  wire logic                 req_write,
   input  wire logic                 req_encrypted,
   // Answer
   output logic                      rsp_valid,
   output logic                      mem_en,
   output logic                      mem_write,
   output szad_pkg::szad_zone_t      mem_zone,
   output logic [3:0]                mem_slot,
   output logic [11:0]               mem_byte,
   output logic [5:0]                mem_len,
   output szad_pkg::szad_status_t    rsp_status
);
   import szad_pkg::*;

   typedef struct packed {
      logic         rsp_valid;
      logic         mem_en;
      logic         mem_write;
      szad_zone_t   zone;
      logic [3:0]   slot;
      logic [11:0]  byte_addr;
      logic [5:0]   len;
      szad_status_t status;
   } szad_state_t;

   szad_state_t state_reg;
   szad_state_t state_next;
   szad_req_if  chk_if ();

   logic [3:0]  dblk;
   logic [1:0]  cfg_blk;
   logic        otp_blk;
   logic [2:0]  word;
   logic [3:0]  slot;
   logic        ok;
   logic [11:0] byte_addr;

   // Field extraction; unused upper bits never reach the decode
   assign word    = req_addr[`SZAD_WORD_MSB:`SZAD_WORD_LSB];
   assign cfg_blk = req_addr[`SZAD_CFG_BLK_MSB:`SZAD_CFG_BLK_LSB];
   assign otp_blk = req_addr[`SZAD_OTP_BLK_BIT];
   assign slot    = req_addr[`SZAD_SLOT_MSB:`SZAD_SLOT_LSB];

   // Block width depends on slot size class
   always_comb begin
      if (slot <= `SZAD_SMALL_SLOT_MAX) begin
         dblk = {3'h0, req_addr[`SZAD_DBLK_LSB]};
      end else if (slot == `SZAD_BIG_SLOT) begin
         dblk = req_addr[`SZAD_DBLK_MSB:`SZAD_DBLK_LSB];
      end else begin
         dblk = {2'h0, req_addr[`SZAD_DBLK_LSB+1:`SZAD_DBLK_LSB]};
      end
   end

   assign chk_if.slot      = slot;
   assign chk_if.blk       = dblk;
   assign chk_if.word      = word;
   assign chk_if.is_block  = req_block;
   assign chk_if.is_write  = req_write;
   assign chk_if.encrypted = req_encrypted;

   szad_slot_check u_chk (
      .req (chk_if)
   );

   // Zone legality and byte position
   always_comb begin
      ok        = 1'b0;
      byte_addr = `SZAD_RST_BYTE;
      unique case (req_zone)
         SZAD_ZONE_CFG: begin
            ok        = !req_write;
            byte_addr = {5'h00, cfg_blk, word, 2'b00};
         end
         SZAD_ZONE_OTP: begin
            ok        = !req_write;
            byte_addr = {6'h00, otp_blk, word, 2'b00};
         end
         SZAD_ZONE_DATA: begin
            ok        = chk_if.ok;
            byte_addr = {3'h0, dblk, word, 2'b00};
         end
         default: begin
            ok        = 1'b0; // Illegal zone code
            byte_addr = `SZAD_RST_BYTE;
         end
      endcase
      // Blocks start on word 0 of the block
      if (req_block && word != 3'h0) begin
         ok = 1'b0;
      end
   end

   // Register the decision; a refusal zeroes enable, write, byte and length but still passes zone and slot
   always_comb begin
      state_next           = state_reg;
      state_next.rsp_valid = req_valid;
      state_next.mem_en    = 1'b0;
      if (req_valid) begin
         state_next.mem_en    = ok;
         state_next.mem_write = ok & req_write;
         state_next.zone      = req_zone;
         state_next.slot      = (req_zone == SZAD_ZONE_DATA) ? slot : 4'h0;
         state_next.byte_addr = ok ? byte_addr : `SZAD_RST_BYTE;
         state_next.len       = ok ? (req_block ? 6'h20 : 6'h04) : 6'h00;
         if (ok) begin
            state_next.status = SZAD_ST_OK;
         end else if ((req_zone == SZAD_ZONE_CFG ||
                       req_zone == SZAD_ZONE_OTP) && req_write) begin
            // Illegal zone codes fall through to the execution refusal
            state_next.status = SZAD_ST_PARSE;
         end else begin
            state_next.status = SZAD_ST_EXEC;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rsp_valid  = state_reg.rsp_valid;
   assign mem_en     = state_reg.mem_en;
   assign mem_write  = state_reg.mem_write;
   assign mem_zone   = state_reg.zone;
   assign mem_slot   = state_reg.slot;
   assign mem_byte   = state_reg.byte_addr;
   assign mem_len    = state_reg.len;
   assign rsp_status = state_reg.status;
endmodule
`default_nettype wire

/* File: sim/szad_decoder_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module szad_decoder_sva (
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   nrst,
   // Request
   input wire logic                   req_valid,
   input var szad_pkg::szad_zone_t    req_zone,
   input wire logic [15:0]            req_addr,
   input wire logic                   req_block,
   input wire logic                   req_write,
   // Answer
   input wire logic                   rsp_valid,
   input wire logic                   mem_en,
   input wire logic                   mem_write,
   input wire logic [11:0]            mem_byte,
   input wire logic [5:0]             mem_len,
   input var szad_pkg::szad_status_t  rsp_status
);
   import szad_pkg::*;
   logic [15:0] addr_q;
   // Address of the request being answered
   always_ff @(posedge ref_clk) begin
      addr_q <= req_addr;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   chk_answer_late: assert property (req_valid |=> rsp_valid)
      else $error("answer missing");
   chk_answer_spur: assert property (!req_valid |=> !rsp_valid && !mem_en)
      else $error("answer without request");
   chk_ro_zone: assert property (req_valid && req_write &&
      req_zone inside {SZAD_ZONE_CFG, SZAD_ZONE_OTP}
      |=> !mem_en && rsp_status == SZAD_ST_PARSE) else $error("ro write");
   chk_cfg_offset: assert property (req_valid && !req_write &&
      !req_block && req_zone == SZAD_ZONE_CFG
      |=> mem_en && mem_byte == {5'h00, addr_q[4:0], 2'h0})
      else $error("cfg offset");
   chk_otp_offset: assert property (req_valid && !req_write &&
      !req_block && req_zone == SZAD_ZONE_OTP
      |=> mem_en && mem_byte == {6'h00, addr_q[3:0], 2'h0})
      else $error("otp offset");
   chk_len_unit: assert property (req_valid |=> mem_len ==
      (!mem_en ? 6'h00 : $past(req_block) ? 6'h20 : 6'h04))
      else $error("length");
   chk_denied_slot: assert property (req_valid &&
      req_zone == SZAD_ZONE_DATA && req_addr[6:3] inside {[0:4], 7}
      |=> !mem_en && rsp_status == SZAD_ST_EXEC) else $error("slot");
   chk_bad_zone: assert property (req_valid && req_zone == 2'b11
      |=> !mem_en && rsp_status == SZAD_ST_EXEC) else $error("bad zone");
   chk_refuse_clear: assert property (rsp_valid && !mem_en |->
      rsp_status != SZAD_ST_OK && mem_byte == 12'h000 && !mem_write)
      else $error("refusal");
endmodule
bind szad_decoder szad_decoder_sva i_szad_decoder_sva (.ref_clk(ref_clk),
   .nrst(nrst), .req_valid(req_valid), .req_zone(req_zone),
   .req_addr(req_addr), .req_block(req_block), .req_write(req_write),
   .rsp_valid(rsp_valid), .mem_en(mem_en), .mem_write(mem_write),
   .mem_byte(mem_byte), .mem_len(mem_len), .rsp_status(rsp_status));
`default_nettype wire

/* File: sim/szad_host.sv */
`timescale 1ns/1ps
`default_nettype none
module szad_host (
   // Clock
   input wire logic              ref_clk,
   // Request
   output logic                  req_valid,
   output szad_pkg::szad_zone_t  req_zone,
   output logic [15:0]           req_addr,
   output logic [2:0]            req_kind
);
   import szad_pkg::*;
   // Quiet bus until the first request
   initial begin
      {req_valid, req_addr, req_kind} = 20'h00000;
      req_zone = SZAD_ZONE_CFG;
   end
   // Word or block units only, one per cycle
   task automatic send(logic [20:0] r);
      req_valid = 1'b1;
      req_zone = szad_zone_t'(r[20:19]);
      {req_addr, req_kind} = r[18:0];
      @(posedge ref_clk);
      #2;
   endtask
   // Stale address inverted so it cannot pass for valid
   task automatic idle();
      req_valid = 1'b0;
      req_addr = ~req_addr;
      @(posedge ref_clk);
      #2;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import szad_pkg::*;
   logic ref_clk, nrst, req_valid, rsp_valid, mem_en, mem_write;
   logic [2:0] kind;
   szad_zone_t req_zone, mem_zone;
   szad_status_t rsp_status;
   logic [15:0] req_addr;
   logic [11:0] mem_byte;
   logic [5:0] mem_len;
   logic [3:0] mem_slot;
   logic [20:0] r;
   logic [33:0] exp_q[$];
   int bad_count, checked;
   // Corners: zone, address, {block, write, encrypted}
   logic [20:0] tbl[16] = '{{2'h0, 16'h001F, 3'h0}, {2'h0, 16'hABFF, 3'h0},
      {2'h0, 16'h0018, 3'h4}, {2'h0, 16'h0008, 3'h2}, {2'h1, 16'h00FF, 3'h0},
      {2'h1, 16'h0008, 3'h6}, {2'h2, 16'h0140, 3'h4}, {2'h2, 16'h0C47, 3'h0},
      {2'h2, 16'h0D40, 3'h4}, {2'h2, 16'h0251, 3'h0}, {2'h2, 16'h0252, 3'h0},
      {2'h2, 16'h0250, 3'h4}, {2'h2, 16'h0129, 3'h3}, {2'h2, 16'h0128, 3'h3},
      {2'h2, 16'h00C0, 3'h0}, {2'h3, 16'h0000, 3'h0}};
   szad_host i_szad_host (.ref_clk(ref_clk), .req_valid(req_valid),
      .req_zone(req_zone), .req_addr(req_addr), .req_kind(kind));
   szad_decoder i_szad_decoder (.ref_clk(ref_clk), .nrst(nrst),
      .req_valid(req_valid), .req_zone(req_zone), .req_addr(req_addr),
      .req_block(kind[2]), .req_write(kind[1]), .req_encrypted(kind[0]),
      .rsp_valid(rsp_valid), .mem_en(mem_en), .mem_write(mem_write),
      .mem_zone(mem_zone), .mem_slot(mem_slot), .mem_byte(mem_byte),
      .mem_len(mem_len), .rsp_status(rsp_status));
   // Expected {en, status, byte, len, write, zone, slot}
   function automatic logic [33:0] model(logic [1:0] z, logic [15:0] a,
                                         logic [2:0] m);
      int s, k, wd, lb, lw, st;
      bit p;
      s = a[6:3];
      wd = a[2:0];
      lb = s < 8 ? 1 : s == 8 ? 12 : 2;
      lw = s < 8 ? 1 : s == 8 ? 8 : 2;
      k = s < 8 ? a[8] : s == 8 ? a[11:8] : a[9:8];
      p = m[1] ? (m[0] ? s inside {5, 6} : bit'(16'hA300 >> s))
         : bit'(16'hFD00 >> s);
      if (z < 2) begin
         k = z ? a[3] : a[4:3];
         lb = z ? 1 : 3;
         lw = 8;
         s = 0;
      end
      lb = z == 3 ? -1 : lb;
      st = (z < 2 && m[1]) ? 3 : (k < lb || k == lb && (m[2] ? lw == 8 :
         wd < lw)) && !(m[2] && wd != 0) && (p || z < 2) ? 0 : 15;
      return {st == 0, 8'(st), st == 0 ? 12'(k * 32 + wd * 4) : 12'h000,
         st == 0 ? (m[2] ? 6'h20 : 6'h04) : 6'h00, m[1] && st == 0, z,
         st == 0 ? 4'(s) : 4'h0};
   endfunction
   task automatic chk(string n, logic [33:0] s, logic [33:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Answer is due one cycle after each taken request
   always @(posedge ref_clk) begin
      if (nrst === 1'b1) begin
         chk("rsp_valid", 34'(rsp_valid), 34'(exp_q.size()));
         if (exp_q.size() > 0) chk("answer", {mem_en, rsp_status, mem_byte,
            mem_len, mem_write, mem_zone, mem_en ? mem_slot : 4'h0},
            exp_q.pop_front());
         if (req_valid) exp_q.push_back(model(req_zone, req_addr, kind));
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Cuts a hang short; the run needs some 400 cycles
   initial begin
      repeat (3000) @(posedge ref_clk);
      bad_count++;
      results();
   end
   initial begin
      nrst = 1'b0;
      void'($urandom(32'h9528));
      repeat (12) @(posedge ref_clk);
      #2 nrst = 1'b1;
      i_szad_host.idle();
      foreach (tbl[i]) i_szad_host.send(tbl[i]);
      i_szad_host.idle();
      $display("test corners done");
      // Every slot read, clear write and encrypted write, back to back
      for (int s = 0; s < 48; s++) i_szad_host.send({2'h2, 9'h000,
         4'(s / 3), 3'h0, s % 3 == 0 ? 3'h0 : s % 3 == 1 ? 3'h2 : 3'h3});
      i_szad_host.idle();
      $display("test slot policy done");
      // Cfg/OTP writes kept on word 0 of a block: refusal order there is open
      for (int n = 0; n < 300; n++) begin
         r = 21'($urandom);
         if (r[20:19] < 2 && r[1]) r[5:3] = 3'h0;
         i_szad_host.send(r);
      end
      i_szad_host.idle();
      i_szad_host.idle();
      $display("test random done");
      results();
   end
endmodule
`default_nettype wire
